// ---- rtl/lfd_pkg.sv ----
// lfd_pkg: shared constants, timing figures and gamma table of the led fade dimming block
package lfd_pkg;

	// ==========================================================
	// channel and input layout
	localparam int unsigned CH_NUM      = 2;        // main current channels
	localparam int unsigned IN_NUM      = 3;        // debounced inputs: dimming input plus two enables
	localparam int unsigned IN_DIM      = 0;        // debouncer lane of the shared dimming input
	localparam int unsigned IN_EN_BASE  = 1;        // first debouncer lane of the enable inputs
	localparam int unsigned TSET_W      = 10;       // fade time setting width, in kilo-ohm units

	// ==========================================================
	// clock and timing figures
	localparam int unsigned CLK_PERIOD_NS   = 20;        // 50 MHz system clock
	localparam int unsigned DEBOUNCE_MS     = 37;        // stable time before an input change counts
	localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned DEB_CNT_W       = 21;        // holds DEBOUNCE_CYC
	localparam int unsigned PWM_FREQ_HZ     = 220;       // internal dimming pwm rate
	localparam int unsigned PWM_PERIOD_CYC  = 1000000000 / (PWM_FREQ_HZ * CLK_PERIOD_NS);
	localparam int unsigned GAMMA_FULL      = 1000;      // gamma table full scale
	localparam int unsigned SLOT_CYC        = PWM_PERIOD_CYC / GAMMA_FULL;
	localparam int unsigned TSET_UNIT_NS    = 2500000;   // fade time per kilo-ohm of setting
	localparam int unsigned GAMMA_STEPS     = 63;        // entries of the gamma table
	localparam int unsigned GAMMA_LAST      = GAMMA_STEPS - 1;
	localparam int unsigned STEP_UNIT_CYC   = TSET_UNIT_NS / (GAMMA_LAST * CLK_PERIOD_NS);
	localparam int unsigned INSTANT_NS      = 70000;     // whole ramp time with a zero setting
	localparam int unsigned INSTANT_CYC     = INSTANT_NS / (GAMMA_LAST * CLK_PERIOD_NS);

	// ==========================================================
	// types
	typedef logic [5:0]  lfd_idx_t;    // gamma index 0..62
	typedef logic [9:0]  lfd_lvl_t;    // intensity 0..1000
	typedef logic [11:0] lfd_cnt_t;    // prescaler counters

	localparam lfd_idx_t IDX_ZERO = 6'h00;
	localparam lfd_idx_t IDX_LAST = 6'h3E;
	localparam lfd_lvl_t LVL_TOP  = 10'h3E7;   // last pwm slot
	localparam lfd_cnt_t SLOT_TOP = lfd_cnt_t'(SLOT_CYC - 1);
	localparam lfd_cnt_t UNIT_TOP = lfd_cnt_t'(STEP_UNIT_CYC - 1);
	localparam lfd_cnt_t INST_TOP = lfd_cnt_t'(INSTANT_CYC - 1);

	// ==========================================================
	// gamma table, intensity scaled to 1000
	localparam lfd_lvl_t GAMMA_TAB [GAMMA_STEPS] = '{
		10'd0,   10'd2,   10'd4,   10'd6,   10'd8,   10'd10,  10'd12,  10'd16,
		10'd20,  10'd24,  10'd28,  10'd32,  10'd36,  10'd42,  10'd48,  10'd54,
		10'd60,  10'd66,  10'd72,  10'd80,  10'd88,  10'd96,  10'd104, 10'd112,
		10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
		10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
		10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
		10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
		10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000
	};

	// intensity of a gamma index; out-of-range indices read as full scale
	function automatic lfd_lvl_t gamma_lookup(input lfd_idx_t idx);
		lfd_lvl_t lvl;
		lvl = GAMMA_TAB[GAMMA_LAST];
		if (idx <= IDX_LAST) begin
			lvl = GAMMA_TAB[idx];
		end
		return lvl;
	endfunction

endpackage

// ---- rtl/lfd_deb_if.sv ----
// lfd_deb_if: raw and debounced input lanes between the controller and its debouncer
interface lfd_deb_if;
	logic [lfd_pkg::IN_NUM-1:0] raw;      // active-sense input levels
	logic [lfd_pkg::IN_NUM-1:0] stable;   // debounced levels
	logic [lfd_pkg::IN_NUM-1:0] change;   // one-cycle pulse when a lane's stable level flips

	modport deb (input raw, output stable, output change);
	modport ctl (output raw, input stable, input change);
endinterface

// ---- rtl/lfd_debounce.sv ----
// lfd_debounce: per-lane debouncer, a new level counts only after a full quiet interval
module lfd_debounce #(
	parameter int unsigned DEB_CYC = lfd_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic   clk_sys_i,
	input  wire logic   rst_n_i,
	// lanes
	lfd_deb_if.deb      deb
);

	// ==========================================================
	// per-lane state
	localparam logic [lfd_pkg::DEB_CNT_W-1:0] CNT_TOP = lfd_pkg::DEB_CNT_W'(DEB_CYC - 1);

	logic [lfd_pkg::DEB_CNT_W-1:0] cnt_r [lfd_pkg::IN_NUM];   // cycles the new level has held
	logic [lfd_pkg::IN_NUM-1:0]    stable_r;                  // accepted level
	logic [lfd_pkg::IN_NUM-1:0]    change_r;                  // flip pulse

	// ==========================================================
	// counting: both edge directions use the same interval
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			stable_r <= '0;
			change_r <= '0;
			for (int i = 0; i < lfd_pkg::IN_NUM; i++) begin
				cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < lfd_pkg::IN_NUM; i++) begin
				change_r[i] <= 1'b0;
				if (deb.raw[i] == stable_r[i]) begin
					// a glitch back to the old level restarts the wait
					cnt_r[i] <= '0;
				end else if (cnt_r[i] == CNT_TOP) begin
					stable_r[i] <= deb.raw[i];
					change_r[i] <= 1'b1;
					cnt_r[i]    <= '0;
				end else begin
					cnt_r[i] <= cnt_r[i] + 1'b1;
				end
			end
		end
	end

	assign deb.stable = stable_r;
	assign deb.change = change_r;

endmodule

// ---- rtl/lfd_dim_ctrl.sv ----
// lfd_dim_ctrl: dimming, fade and supply lockout control of the two main led channels
//
// Overview of operation
// - one dimming input drives both channels together
// - source strap high external, low internal
// - sense strap high: high input is active
// - sense strap low: low input is active
// - external mode bypasses gamma and fade ramp
// - external average current equals full scale times duty
// - internal fade starts after debounce interval passes
// - internal 220 Hz pwm steps gamma sequence
// - positive external: edges switch outputs instantly
// - negative external: edges switch outputs instantly
// - positive internal: rise fades up, fall down
// - negative internal: rise fades down, fall up
// - supply low: sources off, latch kept
// - deep supply low resets latch, outputs off
// - sources return only on supply recovered
// - separate rise and fall fade time settings
// - zero setting gives near instant ramp
// - fixed 63-entry gamma table scaled to 1000
// - new toggle reverses a fade mid-ramp
// - debounce applies to both enable edges
module lfd_dim_ctrl #(
	parameter int unsigned DEB_CYC    = lfd_pkg::DEBOUNCE_CYC   // debounce length, shorten in simulation
) (
	// clock and reset
	input  wire logic                            clk_sys_i,
	input  wire logic                            rst_n_i,
	// strap pins, static after power-on
	input  wire logic                            dim_source_select_strap_i,
	input  wire logic                            input_sense_select_strap_i,
	// dimming and enable inputs
	input  wire logic                            dim_in_i,
	input  wire logic [lfd_pkg::CH_NUM-1:0]      channel_enable_inputs_i,
	// fade time settings in kilo-ohm units, zero means instant
	input  wire logic [lfd_pkg::TSET_W-1:0]      fade_rise_time_setting_i,
	input  wire logic [lfd_pkg::TSET_W-1:0]      fade_fall_time_setting_i,
	// supply monitor indications
	input  wire logic                            supply_low_i,
	input  wire logic                            supply_deep_low_i,
	input  wire logic                            supply_recovered_i,
	// current source switches
	output logic      [lfd_pkg::CH_NUM-1:0]      main_current_outputs_o,
	// status
	output logic      [lfd_pkg::CH_NUM-1:0]      channel_latch_o,
	output logic                                 supply_lockout_o
);

	// ==========================================================
	// declarations
	lfd_deb_if deb_lanes ();                                        // debouncer lanes

	logic                          ext_mode;                       // external pwm source selected
	logic                          dim_active;                     // dimming input in its active sense
	logic                          lockout_r;                      // sources held off by supply monitor
	logic [lfd_pkg::CH_NUM-1:0]    latch_r;                        // stored enable latch per channel
	lfd_pkg::lfd_idx_t             idx_r [lfd_pkg::CH_NUM];        // fade position per channel
	lfd_pkg::lfd_cnt_t             sub_r;                          // cycles within one pwm slot
	lfd_pkg::lfd_lvl_t             slot_r;                         // pwm slot within the period
	lfd_pkg::lfd_cnt_t             unit_cnt_r;                     // fade time unit prescaler
	lfd_pkg::lfd_cnt_t             inst_cnt_r;                     // instant ramp prescaler
	logic                          unit_tick;                      // one fade time unit elapsed
	logic                          inst_tick;                      // one instant step elapsed
	logic [lfd_pkg::TSET_W-1:0]    step_cnt_r [lfd_pkg::CH_NUM];   // units since last fade step
	logic [lfd_pkg::CH_NUM-1:0]    step_due;                       // channel takes a fade step now
	logic [lfd_pkg::CH_NUM-1:0]    pwm_on;                         // internal pwm level per channel
	logic [lfd_pkg::CH_NUM-1:0]    main_out_r;                     // registered source switches

	// ==========================================================
	// strap decode
	// the straps are read every cycle; they are assumed tied and never moved while running
	assign ext_mode   = dim_source_select_strap_i;
	// xnor with the sense strap turns either polarity into active high
	assign dim_active = ~(dim_in_i ^ input_sense_select_strap_i);

	// ==========================================================
	// debouncer: dimming input and both enables share one interval
	assign deb_lanes.raw = {channel_enable_inputs_i, dim_active};

	lfd_debounce #(
		.DEB_CYC (DEB_CYC)
	) u_debounce (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.deb       (deb_lanes.deb)
	);

	// ==========================================================
	// supply lockout: low turns sources off, only recovered turns them back on
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			lockout_r <= 1'b0;
		end else if (supply_low_i || supply_deep_low_i) begin
			// a low indication wins over a stale recovered indication
			lockout_r <= 1'b1;
		end else if (supply_recovered_i) begin
			lockout_r <= 1'b0;
		end
	end

	// ==========================================================
	// enable latch per channel
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			latch_r <= '0;
		end else if (supply_deep_low_i) begin
			// the deep low loses the latch contents: back to power-on default
			latch_r <= '0;
		end else begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				if (deb_lanes.change[lfd_pkg::IN_EN_BASE + c]) begin
					// a debounced enable change overrides the dimming input
					latch_r[c] <= deb_lanes.stable[lfd_pkg::IN_EN_BASE + c];
				end else if (ext_mode) begin
					// external: follow the raw input, no debounce, edges act at once
					latch_r[c] <= dim_active;
				end else if (deb_lanes.change[lfd_pkg::IN_DIM]) begin
					// internal: a settled new level sets the fade target
					// setting the level already there leaves the channel as it is
					latch_r[c] <= deb_lanes.stable[lfd_pkg::IN_DIM];
				end
			end
		end
	end

	// ==========================================================
	// internal pwm: period split into 1000 slots of equal length
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sub_r  <= '0;
			slot_r <= '0;
		end else if (sub_r == lfd_pkg::SLOT_TOP) begin
			sub_r  <= '0;
			// the slot count wraps once per 220 Hz period
			slot_r <= (slot_r == lfd_pkg::LVL_TOP) ? '0 : slot_r + 1'b1;
		end else begin
			sub_r <= sub_r + 1'b1;
		end
	end

	// a channel is lit in the slots below its gamma intensity
	always_comb begin
		for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
			pwm_on[c] = (slot_r < lfd_pkg::gamma_lookup(idx_r[c]));
		end
	end

	// ==========================================================
	// fade step prescalers, shared by both channels
	assign unit_tick = (unit_cnt_r == lfd_pkg::UNIT_TOP);
	assign inst_tick = (inst_cnt_r == lfd_pkg::INST_TOP);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			unit_cnt_r <= '0;
			inst_cnt_r <= '0;
		end else begin
			// one unit is a kilo-ohm's share of one of the 62 steps
			unit_cnt_r <= unit_tick ? '0 : unit_cnt_r + 1'b1;
			// instant ramp runs the whole table in about 70 us
			inst_cnt_r <= inst_tick ? '0 : inst_cnt_r + 1'b1;
		end
	end

	// ==========================================================
	// step timing per channel, setting picked by fade direction
	always_comb begin
		for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
			if (latch_r[c]) begin
				// rising: zero setting steps on the fast tick
				step_due[c] = (fade_rise_time_setting_i == '0) ? inst_tick :
					(unit_tick && (step_cnt_r[c] >= fade_rise_time_setting_i - 1'b1));
			end else begin
				step_due[c] = (fade_fall_time_setting_i == '0) ? inst_tick :
					(unit_tick && (step_cnt_r[c] >= fade_fall_time_setting_i - 1'b1));
			end
		end
	end

	// units counted since the last step; cleared by each step
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				step_cnt_r[c] <= '0;
			end
		end else begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				if (step_due[c]) begin
					step_cnt_r[c] <= '0;
				end else if (unit_tick) begin
					step_cnt_r[c] <= step_cnt_r[c] + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// fade position: walks toward the latch, one table entry a step
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || supply_deep_low_i) begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				idx_r[c] <= lfd_pkg::IDX_ZERO;
			end
		end else begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				if (ext_mode) begin
					// external: no ramp, the position just mirrors the switch
					idx_r[c] <= latch_r[c] ? lfd_pkg::IDX_LAST : lfd_pkg::IDX_ZERO;
				end else if (step_due[c]) begin
					// the target is read every step, so a new toggle reverses mid-ramp
					if (latch_r[c] && idx_r[c] != lfd_pkg::IDX_LAST) begin
						idx_r[c] <= idx_r[c] + 1'b1;
					end else if (!latch_r[c] && idx_r[c] != lfd_pkg::IDX_ZERO) begin
						idx_r[c] <= idx_r[c] - 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// source switches
	// held off through lockout while the latch keeps its state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			main_out_r <= '0;
		end else begin
			for (int c = 0; c < lfd_pkg::CH_NUM; c++) begin
				if (lockout_r || supply_low_i || supply_deep_low_i) begin
					main_out_r[c] <= 1'b0;
				end else if (ext_mode) begin
					// full scale while the input is active, so average follows duty
					main_out_r[c] <= latch_r[c];
				end else begin
					main_out_r[c] <= pwm_on[c];
				end
			end
		end
	end

	// ==========================================================
	// outputs
	assign main_current_outputs_o = main_out_r;
	assign channel_latch_o        = latch_r;
	assign supply_lockout_o       = lockout_r;

endmodule

// ---- bench/lfd_dim_ctrl_sva.sv ----
// lfd_dim_ctrl_sva: port-level assertions of the led fade dimming block
module lfd_dim_ctrl_sva #(
	parameter int unsigned DEB_CYC = lfd_pkg::DEBOUNCE_CYC   // must match the bound design
) (
	// clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	// straps, dimming and enable inputs, fade settings
	input  wire logic                        dim_source_select_strap_i,
	input  wire logic                        input_sense_select_strap_i,
	input  wire logic                        dim_in_i,
	input  wire logic [lfd_pkg::CH_NUM-1:0]  channel_enable_inputs_i,
	input  wire logic [lfd_pkg::TSET_W-1:0]  fade_rise_time_setting_i,
	input  wire logic [lfd_pkg::TSET_W-1:0]  fade_fall_time_setting_i,
	// supply monitor
	input  wire logic                        supply_low_i,
	input  wire logic                        supply_deep_low_i,
	input  wire logic                        supply_recovered_i,
	// watched outputs
	input  wire logic [lfd_pkg::CH_NUM-1:0]  main_current_outputs_o,
	input  wire logic [lfd_pkg::CH_NUM-1:0]  channel_latch_o,
	input  wire logic                        supply_lockout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// helper logic
	logic                        act_w;       // dimming input in active sense
	logic                        act_prev_r;  // last sampled active level
	logic [31:0]                 dim_cnt_r;   // cycles the active level has held
	logic [lfd_pkg::CH_NUM-1:0]  en_prev_r;   // last sampled enable pins
	logic [31:0]                 en_cnt_r;    // cycles since the enable pins moved
	logic                        quiet_w;     // no debounced enable flip can be pending

	assign act_w   = dim_in_i ~^ input_sense_select_strap_i;
	// enables win when they flip, so relations on the dimming path wait them out
	assign quiet_w = en_cnt_r > DEB_CYC + 32'd4;

	// dimming hold counter, saturating so a long hold never wraps
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			act_prev_r <= 1'b0;
			dim_cnt_r  <= 32'h00000000;
		end else begin
			act_prev_r <= act_w;
			if (act_w != act_prev_r) begin
				dim_cnt_r <= 32'h00000000;
			end else if (dim_cnt_r != 32'hFFFFFFFF) begin
				dim_cnt_r <= dim_cnt_r + 32'h00000001;
			end
		end
	end

	// enable quiet counter
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			en_prev_r <= '0;
			en_cnt_r  <= 32'h00000000;
		end else begin
			en_prev_r <= channel_enable_inputs_i;
			if (channel_enable_inputs_i != en_prev_r) begin
				en_cnt_r <= 32'h00000000;
			end else if (en_cnt_r != 32'hFFFFFFFF) begin
				en_cnt_r <= en_cnt_r + 32'h00000001;
			end
		end
	end

	// ==========================================================
	// assertions
	ext_latch_a : assert property (
		dim_source_select_strap_i && quiet_w && !$past(supply_low_i) && !$past(supply_deep_low_i)
		|-> channel_latch_o == {2{$past(act_w)}}) else $error("latch does not follow the dimming input");
	ext_out_a : assert property (
		dim_source_select_strap_i && quiet_w && !$past(supply_lockout_o) && !$past(supply_low_i)
		&& !$past(supply_deep_low_i) && !$past(supply_low_i, 2) && !$past(supply_deep_low_i, 2)
		|-> main_current_outputs_o == {2{$past(act_w, 2)}}) else $error("outputs do not switch with the input");
	lock_set_a : assert property (
		supply_low_i || supply_deep_low_i |=> supply_lockout_o && main_current_outputs_o == '0)
		else $error("supply low did not lock the sources out");
	lock_hold_a : assert property (
		supply_lockout_o && !supply_recovered_i |=> supply_lockout_o) else $error("lockout left without recovery");
	lock_dark_a : assert property (
		supply_lockout_o |-> main_current_outputs_o == '0) else $error("source on during lockout");
	deep_clear_a : assert property (
		supply_deep_low_i |=> channel_latch_o == '0) else $error("deep low kept the latch");
	reset_clear_a : assert property (
		$rose(rst_n_i) |-> main_current_outputs_o == '0 && channel_latch_o == '0 && !supply_lockout_o)
		else $error("outputs not clear after reset");
	int_debounce_a : assert property (
		!dim_source_select_strap_i && quiet_w && $changed(channel_latch_o) && !$past(supply_deep_low_i)
		|-> $past(dim_cnt_r, 2) >= DEB_CYC - 32'd3 && channel_latch_o == {2{$past(act_w, 2)}})
		else $error("fade started before the input settled");
endmodule

bind lfd_dim_ctrl lfd_dim_ctrl_sva #(.DEB_CYC(DEB_CYC)) u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.dim_source_select_strap_i(dim_source_select_strap_i), .input_sense_select_strap_i(input_sense_select_strap_i),
	.dim_in_i(dim_in_i), .channel_enable_inputs_i(channel_enable_inputs_i),
	.fade_rise_time_setting_i(fade_rise_time_setting_i), .fade_fall_time_setting_i(fade_fall_time_setting_i),
	.supply_low_i(supply_low_i), .supply_deep_low_i(supply_deep_low_i), .supply_recovered_i(supply_recovered_i),
	.main_current_outputs_o(main_current_outputs_o), .channel_latch_o(channel_latch_o),
	.supply_lockout_o(supply_lockout_o));

// ---- bench/lfd_dim_src.sv ----
// lfd_dim_src: model of the external pwm or level source on the shared dimming pin
module lfd_dim_src (
	// clock
	input  wire logic         clk_i,
	// waveform shape
	input  wire logic         pwm_en_i,
	input  wire logic [15:0]  period_i,
	input  wire logic [15:0]  duty_i,
	input  wire logic         level_i,
	// dimming pin
	output logic              dim_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_r = 16'h0000;   // position inside the current period

	initial dim_o = 1'b0;

	// period counter; periods are scaled down to cycles, real sources run far slower
	always @(negedge clk_i) begin
		if (!pwm_en_i || cnt_r >= period_i - 16'h0001) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// active level for the first duty_i cycles, any duty from none to full
	always @(negedge clk_i) begin
		dim_o <= pwm_en_i ? ((cnt_r < duty_i) ? level_i : ~level_i) : level_i;
	end
endmodule

// ---- bench/lfd_dim_ctrl_tb.sv ----
// lfd_dim_ctrl_tb: self-checking bench of the led fade dimming block
module lfd_dim_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// settings and signals
	localparam int unsigned DEB  = 20;                        // short debounce keeps the run brief
	localparam int unsigned RAMP = lfd_pkg::GAMMA_LAST * lfd_pkg::INSTANT_CYC; // whole ramp with a zero setting
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        src_r     = 1'b1;       // source strap
	logic        sense_r   = 1'b1;       // sense strap
	logic [1:0]  en_r      = 2'b00;      // enable pins
	logic [9:0]  rise_r    = 10'h000;    // fade-up setting
	logic [9:0]  fall_r    = 10'h000;    // fade-down setting
	logic        low_r     = 1'b0;
	logic        deep_r    = 1'b0;
	logic        rec_r     = 1'b0;
	logic        pwm_en_r  = 1'b0;       // partner waveform control
	logic [15:0] per_r     = 16'h0020;
	logic [15:0] duty_r    = 16'h0000;
	logic        lvl_r     = 1'b0;
	logic        dim_w;
	logic [1:0]  out_w;
	logic [1:0]  latch_w;
	logic        lock_w;
	logic        a0, a1, bad;
	logic [31:0] ones;
	int          err_total = 0;
	int          n_compared = 0;
	int unsigned seed_v;

	always #10 clk_sys_i = ~clk_sys_i;

	lfd_dim_ctrl #(.DEB_CYC(DEB)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.dim_source_select_strap_i(src_r), .input_sense_select_strap_i(sense_r), .dim_in_i(dim_w),
		.channel_enable_inputs_i(en_r), .fade_rise_time_setting_i(rise_r), .fade_fall_time_setting_i(fall_r),
		.supply_low_i(low_r), .supply_deep_low_i(deep_r), .supply_recovered_i(rec_r),
		.main_current_outputs_o(out_w), .channel_latch_o(latch_w), .supply_lockout_o(lock_w));
	lfd_dim_src u_src (.clk_i(clk_sys_i), .pwm_en_i(pwm_en_r), .period_i(per_r), .duty_i(duty_r),
		.level_i(lvl_r), .dim_o(dim_w));

	// ==========================================================
	// helpers
	function automatic logic pin_of(input logic act);
		return act ~^ sense_r;   // pin level that means active or idle
	endfunction
	function automatic logic [1:0] both(input logic a);
		return {2{a}};           // both channels move together
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// reset with new straps, then let the enable debouncers settle
	task automatic start(input logic src, input logic sense, input logic [9:0] up);
		pwm_en_r = 1'b0; src_r = src; sense_r = sense; rise_r = up; fall_r = 10'h000;
		lvl_r = pin_of(1'b0); rst_n_i = 1'b0;
		cyc(4);
		chk(out_w, 2'b00);
		chk(latch_w, 2'b00);
		rst_n_i = 1'b1;
		cyc(DEB + 10);
	endtask
	// outputs must hold one value for n cycles
	task automatic solid(input logic [1:0] exp, input int n);
		bad = 1'b0;
		repeat (n) begin
			cyc(1);
			if (out_w !== exp) bad = 1'b1;
		end
		chk(bad, 1'b0);
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		seed_v = $urandom(32'h10a7);
		// external mode, both senses: duty 0, full and random
		for (int s = 0; s < 2; s++) begin
			start(1'b1, s[0], 10'h000);
			for (int k = 0; k < 3; k++) begin
				per_r = 16'(20 + $urandom_range(40));
				duty_r = (k == 0) ? 16'h0000 : (k == 1) ? per_r : 16'($urandom_range(per_r - 1, 1));
				lvl_r = pin_of(1'b1); pwm_en_r = 1'b1; ones = 32'h0;
				cyc(2 * per_r);
				@(posedge clk_sys_i) a0 = dim_w ~^ sense_r;
				repeat (10 * per_r) begin
					@(posedge clk_sys_i) a1 = a0;
					a0 = dim_w ~^ sense_r;
					@(negedge clk_sys_i);
					chk(out_w, both(a1));
					ones = ones + 32'(out_w[0]);
				end
				chk(ones, 32'(duty_r) * 10);
			end
			$display("external sense %0d finished", s);
		end
		// supply lockout, latch keep, deep low and recovery
		start(1'b1, 1'b1, 10'h000);
		lvl_r = pin_of(1'b1); cyc(3);
		chk(out_w, 2'b11);
		low_r = 1'b1; cyc(2);
		chk(out_w, 2'b00);
		chk(latch_w, 2'b11);
		chk(lock_w, 1'b1);
		low_r = 1'b0; cyc(5);
		chk(out_w, 2'b00);
		rec_r = 1'b1; cyc(1); rec_r = 1'b0; cyc(3);
		chk(out_w, 2'b11);
		deep_r = 1'b1; cyc(2);
		chk(latch_w, 2'b00);
		chk(out_w, 2'b00);
		deep_r = 1'b0; rec_r = 1'b1; cyc(1); rec_r = 1'b0;
		$display("supply lockout finished");
		// enable debounce on both edges and priority over the idle dimming input
		start(1'b0, 1'b1, 10'h000);
		en_r = 2'b10; cyc($urandom_range(DEB - 4, 1)); en_r = 2'b00; cyc(DEB + 6);
		chk(latch_w, 2'b00);
		en_r = 2'b10; cyc(DEB - 3);
		chk(latch_w, 2'b00);
		cyc(8);
		chk(latch_w, 2'b10);
		en_r = 2'b00; cyc(DEB - 3);
		chk(latch_w, 2'b10);
		cyc(8);
		chk(latch_w, 2'b00);
		$display("enable debounce finished");
		// internal mode, both senses: glitch, fade up, fade down, reversal
		for (int s = 0; s < 2; s++) begin
			start(1'b0, s[0], 10'h000);
			lvl_r = pin_of(1'b1); cyc($urandom_range(DEB - 4, 1)); lvl_r = pin_of(1'b0); cyc(DEB + 6);
			chk(latch_w, 2'b00);
			lvl_r = pin_of(1'b1); cyc(DEB - 3);
			chk(latch_w, 2'b00);
			cyc(8);
			chk(latch_w, 2'b11);
			cyc(RAMP + 100);
			solid(2'b11, 400);
			lvl_r = pin_of(1'b0); cyc(DEB + 8);
			chk(latch_w, 2'b00);
			cyc(RAMP + 100);
			solid(2'b00, 400);
			lvl_r = pin_of(1'b1); cyc(DEB + 1000); lvl_r = pin_of(1'b0); cyc(DEB + 1300);
			solid(2'b00, 400);
			$display("internal sense %0d finished", s);
		end
		// slow rise setting still low after an instant ramp would be done
		start(1'b0, 1'b1, 10'h001);
		lvl_r = pin_of(1'b1); cyc(DEB + 8);
		chk(latch_w, 2'b11);
		cyc(4000); bad = 1'b0;
		repeat (1000) begin
			cyc(1);
			if (out_w !== 2'b11) bad = 1'b1;
		end
		chk(bad, 1'b1);
		lvl_r = pin_of(1'b0); cyc(DEB + 400);
		solid(2'b00, 300);
		$display("fade setting finished");
		end_sim();
	end

	// watchdog, about two and a half times the expected run
	initial begin
		repeat (80000) @(posedge clk_sys_i);
		err_total++;
		$display("Error at %0t: run timed out", $time);
		end_sim();
	end
endmodule
